/* File: ist_pkg.sv */
// constants, structs and register map of the two-wire bus status flag block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ist_pkg;

  // ---------------------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_BUS_STATUS = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_TX_HOLDING = 8'h0c;
  localparam logic [7:0] ADDR_RX_HOLDING = 8'h10;

  // ---------------------------------------------------------------------------
  // bus_status field positions
  // ---------------------------------------------------------------------------
  localparam int BIT_ACK = 15;
  localparam int BIT_TXACT = 14;
  localparam int BIT_BCOL = 10;
  localparam int BIT_GCALL = 9;
  localparam int BIT_TEN = 8;
  localparam int BIT_WCOL = 7;
  localparam int BIT_ROV = 6;
  localparam int BIT_DNA = 5;
  localparam int BIT_STOP = 4;

  // clearable-by-one bits of bus_status
  localparam logic [15:0] STATUS_W1C_MASK = 16'h04c0;

  // interrupt event bit positions
  localparam int EV_ACK_DONE = 0;
  localparam int EV_BCOL = 1;
  localparam int EV_WCOL = 2;
  localparam int EV_ROV = 3;
  localparam int EV_STOP = 4;
  localparam int EV_W = 5;

  // reset values
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [4:0] RST_EVENTS = 5'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // events coming from the protocol engine and detectors
  typedef struct packed {
    logic ack_slot_end;
    logic ack_is_nack;
    logic master_tx_start;
    logic collision;
    logic master_op;
    logic gcall_match;
    logic ten_second_match;
    logic addr_match;
    logic slave_data_byte;
    logic start_seen;
    logic stop_seen;
    logic rx_byte_done;
    logic [7:0] rx_byte;
    logic busy;
  } ist_bus_ev_t;

  // flag storage
  typedef struct packed {
    logic ack_result_flag;
    logic master_tx_active;
    logic bus_collision_flag;
    logic general_call_flag;
    logic ten_bit_match_flag;
    logic tx_write_collision;
    logic rx_overflow_flag;
    logic data_not_addr;
    logic stop_seen_flag;
  } ist_flags_t;

endpackage

/* File: ist_sticky.sv */
// sticky event bits with write-one clear, set wins over clear
`timescale 1ns/10ps
module ist_sticky #(
  parameter int W = 6
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ce,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // set has priority over a simultaneous clear
  always_comb begin
    nxt_q = (q_ff & ~clr_i) | set_i;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      q_ff <= '0;
    end else if (ce) begin
      q_ff <= nxt_q;
    end
  end

  assign q_o = q_ff;

endmodule

/* File: ist_status_top.sv */
// two-wire bus status flag logic with AXI4-Lite register slave and interrupt
`timescale 1ns/10ps
module ist_status_top (
  // clock, asynchronous reset and freeze enable
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // bus event inputs
  input wire ist_pkg::ist_bus_ev_t bus_ev,
  // transmit side toward the shifter
  output logic tx_load,
  output logic [7:0] tx_data,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  typedef struct packed {
    // flags shown in bus_status
    ist_pkg::ist_flags_t flags;
    // receive holding register and its full mark
    logic [7:0] rx_holding_reg;
    logic rx_full;
    // transmit holding register and load strobe
    logic [7:0] tx_holding_reg;
    logic tx_load;
    // enables of the interrupt events
    logic [ist_pkg::EV_W-1:0] irq_mask;
    // write address and data held until both are in
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // channel readies, low while a transfer is open
    logic awready;
    logic wready;
    // write response
    logic bvalid;
    logic [1:0] bresp;
    // read address ready and read response
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // registered interrupt level
    logic irq;
  } ist_state_t;

  // registered state and its next value
  ist_state_t st_ff;
  ist_state_t nxt_st;

  // interrupt events: set pulses, write-one clears, stored bits
  logic [ist_pkg::EV_W-1:0] ev_set;
  logic [ist_pkg::EV_W-1:0] ev_clr;
  logic [ist_pkg::EV_W-1:0] ev_q;

  // status word as software reads it
  logic [15:0] status_word;

  // strobes of an accepted write and an accepted read
  logic wr_fire;
  logic rd_fire;

  // held write data, low bits used by every register
  logic [31:0] wr_lo;

  // ---------------------------------------------------------------------------
  // status word assembly, unused bits zero
  // ---------------------------------------------------------------------------
  always_comb begin
    status_word = ist_pkg::RST_STATUS;
    // flags from the flag store, one bit each
    // positions 13 to 11 and 3 to 0 keep the zero
    status_word[ist_pkg::BIT_ACK] = st_ff.flags.ack_result_flag;
    status_word[ist_pkg::BIT_TXACT] = st_ff.flags.master_tx_active;
    status_word[ist_pkg::BIT_BCOL] = st_ff.flags.bus_collision_flag;
    status_word[ist_pkg::BIT_GCALL] = st_ff.flags.general_call_flag;
    status_word[ist_pkg::BIT_TEN] = st_ff.flags.ten_bit_match_flag;
    status_word[ist_pkg::BIT_WCOL] = st_ff.flags.tx_write_collision;
    status_word[ist_pkg::BIT_ROV] = st_ff.flags.rx_overflow_flag;
    status_word[ist_pkg::BIT_DNA] = st_ff.flags.data_not_addr;
    status_word[ist_pkg::BIT_STOP] = st_ff.flags.stop_seen_flag;
  end

  // write fires once address and data are both held and no response pending
  // a pending response blocks the next write
  // read taken whenever arready stands
  assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
  assign rd_fire = s_axi_arvalid && st_ff.arready;
  assign wr_lo = st_ff.w_data;

  // ---------------------------------------------------------------------------
  // interrupt events and write-one clears
  // ---------------------------------------------------------------------------
  // pulse for the cycle the flag logic sees each event
  always_comb begin
    ev_set = ist_pkg::RST_EVENTS;
    ev_set[ist_pkg::EV_ACK_DONE] = bus_ev.ack_slot_end && st_ff.flags.master_tx_active;
    ev_set[ist_pkg::EV_BCOL] = bus_ev.collision && bus_ev.master_op;
    ev_set[ist_pkg::EV_WCOL] = wr_fire && st_ff.aw_addr == ist_pkg::ADDR_TX_HOLDING
                               && bus_ev.busy;
    ev_set[ist_pkg::EV_ROV] = bus_ev.rx_byte_done && st_ff.rx_full;
    ev_set[ist_pkg::EV_STOP] = bus_ev.stop_seen;
    // ones written to irq_status clear the matching events
    ev_clr = ist_pkg::RST_EVENTS;
    if (wr_fire && st_ff.aw_addr == ist_pkg::ADDR_IRQ_STATUS && st_ff.w_strb[0]) begin
      ev_clr = wr_lo[ist_pkg::EV_W-1:0];
    end
  end

  // stored events, a set in the clearing cycle wins
  // a low clk_en holds them with the rest of the state
  ist_sticky #(
    .W(ist_pkg::EV_W)
  ) u_evt (
    .clk_sys(clk_sys),
    .reset(reset),
    .ce(clk_en),
    .set_i(ev_set),
    .clr_i(ev_clr),
    .q_o(ev_q)
  );

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_load = 1'b0;

    // acknowledge result and transmit activity
    // ack result only moves while a master transmit is open
    if (bus_ev.master_tx_start) begin
      nxt_st.flags.master_tx_active = 1'b1;
    end
    if (bus_ev.ack_slot_end && st_ff.flags.master_tx_active) begin
      nxt_st.flags.ack_result_flag = bus_ev.ack_is_nack;
      nxt_st.flags.master_tx_active = 1'b0;
    end

    // general call and ten-bit match, cleared at stop
    // set applied after the clear, so a same-cycle match wins
    if (bus_ev.stop_seen) begin
      nxt_st.flags.general_call_flag = 1'b0;
      nxt_st.flags.ten_bit_match_flag = 1'b0;
    end
    if (bus_ev.gcall_match) begin
      nxt_st.flags.general_call_flag = 1'b1;
    end
    if (bus_ev.ten_second_match) begin
      nxt_st.flags.ten_bit_match_flag = 1'b1;
    end

    // data or address indication in slave mode
    // address match wins over a data byte in one cycle
    if (bus_ev.addr_match) begin
      nxt_st.flags.data_not_addr = 1'b0;
    end else if (bus_ev.slave_data_byte) begin
      nxt_st.flags.data_not_addr = 1'b1;
    end

    // stop seen last
    // stop wins over a start in one cycle
    if (bus_ev.stop_seen) begin
      nxt_st.flags.stop_seen_flag = 1'b1;
    end else if (bus_ev.start_seen) begin
      nxt_st.flags.stop_seen_flag = 1'b0;
    end

    // receive path: byte moves only when holding register is empty
    // overflowing byte dropped, held byte kept
    if (bus_ev.rx_byte_done) begin
      if (st_ff.rx_full) begin
        nxt_st.flags.rx_overflow_flag = 1'b1;
      end else begin
        nxt_st.rx_holding_reg = bus_ev.rx_byte;
        nxt_st.rx_full = 1'b1;
      end
    end

    // -------------------------------------------------------------------------
    // write channel capture
    // -------------------------------------------------------------------------
    // each channel taken on its own, either order
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
      nxt_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
      nxt_st.wready = 1'b0;
    end

    // -------------------------------------------------------------------------
    // write execute
    // -------------------------------------------------------------------------
    // register update and response in one edge
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = ist_pkg::RESP_OKAY;
      case (st_ff.aw_addr)
        ist_pkg::ADDR_BUS_STATUS: begin
          // clear-by-one; a same-cycle hardware set still wins
          if (st_ff.w_strb[0] && wr_lo[ist_pkg::BIT_WCOL] && !ev_set[ist_pkg::EV_WCOL]) begin
            nxt_st.flags.tx_write_collision = 1'b0;
          end
          if (st_ff.w_strb[0] && wr_lo[ist_pkg::BIT_ROV] && !ev_set[ist_pkg::EV_ROV]) begin
            nxt_st.flags.rx_overflow_flag = 1'b0;
          end
          if (st_ff.w_strb[1] && wr_lo[ist_pkg::BIT_BCOL] && !ev_set[ist_pkg::EV_BCOL]) begin
            nxt_st.flags.bus_collision_flag = 1'b0;
          end
        end
        ist_pkg::ADDR_IRQ_STATUS: begin
          // cleared through the event logic above
        end
        ist_pkg::ADDR_IRQ_MASK: begin
          if (st_ff.w_strb[0]) begin
            nxt_st.irq_mask = wr_lo[ist_pkg::EV_W-1:0];
          end
        end
        ist_pkg::ADDR_TX_HOLDING: begin
          // busy shifter refuses the byte whatever the strobes
          if (bus_ev.busy) begin
            nxt_st.flags.tx_write_collision = 1'b1;
          end else if (st_ff.w_strb[0]) begin
            nxt_st.tx_holding_reg = wr_lo[7:0];
            nxt_st.tx_load = 1'b1;
          end
        end
        default: begin
          // unmapped offset, state left alone
          nxt_st.bresp = ist_pkg::RESP_SLVERR;
        end
      endcase
    end
    // both readies return once the response is taken
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
      nxt_st.awready = 1'b1;
      nxt_st.wready = 1'b1;
    end

    // bus collision set after write handling so the set wins
    // a software clear loses to a same-cycle collision
    if (bus_ev.collision && bus_ev.master_op) begin
      nxt_st.flags.bus_collision_flag = 1'b1;
    end

    // -------------------------------------------------------------------------
    // read channel
    // -------------------------------------------------------------------------
    // data captured at the take, stands until rready
    if (rd_fire) begin
      nxt_st.arready = 1'b0;
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = ist_pkg::RESP_OKAY;
      nxt_st.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        ist_pkg::ADDR_BUS_STATUS: nxt_st.rdata = {16'h0000, status_word};
        // event and mask words zero-extended
        ist_pkg::ADDR_IRQ_STATUS: nxt_st.rdata = {27'h0, ev_q};
        ist_pkg::ADDR_IRQ_MASK: nxt_st.rdata = {27'h0, st_ff.irq_mask};
        ist_pkg::ADDR_TX_HOLDING: nxt_st.rdata = {24'h000000, st_ff.tx_holding_reg};
        ist_pkg::ADDR_RX_HOLDING: begin
          nxt_st.rdata = {24'h000000, st_ff.rx_holding_reg};
          // reading drains the holding register unless a byte lands now
          if (!bus_ev.rx_byte_done) begin
            nxt_st.rx_full = 1'b0;
          end
        end
        default: nxt_st.rresp = ist_pkg::RESP_SLVERR;
      endcase
    end
    // address ready returns once the data is taken
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
      nxt_st.arready = 1'b1;
    end

    // level interrupt from unmasked sticky events
    // one cycle lag between event bit and level
    nxt_st.irq = |(ev_q & st_ff.irq_mask);
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  // reset leaves the ready flops high for a first request
  // low clk_en freezes every flop, handshakes included
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs straight from flops
  // ---------------------------------------------------------------------------
  // transmit side toward the shifter
  assign tx_load = st_ff.tx_load;
  assign tx_data = st_ff.tx_holding_reg;

  // write channel
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;

  // read channel
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  // interrupt level
  assign irq = st_ff.irq;

endmodule

/* File: ist_status_sva.sv */
// port-level assertions for the two-wire bus status flag block
`timescale 1ns/10ps
module ist_status_chk (
  input wire logic clk_sys,
  input wire logic reset,
  input wire ist_pkg::ist_bus_ev_t bus_ev,
  input wire logic tx_load,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [7:0] rd_addr_ff;
  // address of the read in flight
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) rd_addr_ff <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) rd_addr_ff <= s_axi_araddr;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_rsv_zero;
    s_axi_rvalid && rd_addr_ff == ist_pkg::ADDR_BUS_STATUS |-> s_axi_rdata[13:11] == 3'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved status bits set");
  property p_wcol_noload;
    s_wtake ##0 (s_axi_awaddr == ist_pkg::ADDR_TX_HOLDING && bus_ev.busy) |-> !tx_load [*4];
  endproperty
  a_wcol_noload: assert property (p_wcol_noload) else $error("busy write loaded");
  property p_load;
    s_wtake ##0 (s_axi_awaddr == ist_pkg::ADDR_TX_HOLDING && !bus_ev.busy) |-> ##[1:3] tx_load;
  endproperty
  a_load: assert property (p_load) else $error("idle write not loaded");
  property p_bans;
    s_wtake |-> ##2 s_axi_bvalid;
  endproperty
  a_bans: assert property (p_bans) else $error("write response late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rans;
    s_rtake |=> s_axi_rvalid;
  endproperty
  a_rans: assert property (p_rans) else $error("read data late");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_rerr;
    s_rtake ##0 (s_axi_araddr > ist_pkg::ADDR_RX_HOLDING) |=>
      s_axi_rresp == ist_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read not refused");
  property p_ready_back;
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("write ready not restored");
endmodule

/* File: ist_bus_peer.sv */
// far-side model that produces bus event pulses and the busy level
`timescale 1ns/10ps
module ist_bus_peer (
  input wire logic clk_sys,
  output ist_pkg::ist_bus_ev_t bus_ev
);
  initial bus_ev = '0;
  // one-cycle event, then levels only valid with a pulse are scrambled
  task send(input ist_pkg::ist_bus_ev_t e);
    ist_pkg::ist_bus_ev_t t;
    @(posedge clk_sys);
    e.busy = bus_ev.busy;
    bus_ev <= e;
    @(posedge clk_sys);
    t = '0;
    t.busy = e.busy;
    t.rx_byte = ~e.rx_byte;
    t.ack_is_nack = ~e.ack_is_nack;
    bus_ev <= t;
  endtask
  // busy level of the module
  task set_busy(input logic b);
    @(posedge clk_sys);
    bus_ev.busy <= b;
  endtask
endmodule

/* File: ist_status_top_test.sv */
// self-checking bench for the status flag block
`timescale 1ns/10ps
module ist_status_top_test;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  ist_pkg::ist_bus_ev_t bus_ev;
  logic tx_load;
  logic [7:0] tx_data;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic irq;
  int errors = 0;
  int n_checks = 0;
  logic [15:0] m_st = 16'h0;
  logic m_full = 1'b0;
  logic [7:0] m_rx;
  logic [31:0] d;
  logic [1:0] r;
  ist_pkg::ist_bus_ev_t e;
  ist_status_top i_ist_status_top (.*);
  ist_bus_peer i_ist_bus_peer (.clk_sys(clk_sys), .bus_ev(bus_ev));
  initial forever #5 clk_sys = ~clk_sys;
  // ---------------------------------------------------------------------------
  // compare, bus tasks and flag model
  // ---------------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat ($urandom % 3) @(posedge clk_sys);
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom % 3) @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // flag model, one event cycle
  task m_apply(input ist_pkg::ist_bus_ev_t x);
    if (x.ack_slot_end && m_st[ist_pkg::BIT_TXACT]) begin
      m_st[ist_pkg::BIT_ACK] = x.ack_is_nack;
      m_st[ist_pkg::BIT_TXACT] = 1'b0;
    end
    if (x.master_tx_start) m_st[ist_pkg::BIT_TXACT] = 1'b1;
    if (x.collision && x.master_op) m_st[ist_pkg::BIT_BCOL] = 1'b1;
    if (x.stop_seen) m_st[9:8] = 2'h0;
    if (x.gcall_match) m_st[ist_pkg::BIT_GCALL] = 1'b1;
    if (x.ten_second_match) m_st[ist_pkg::BIT_TEN] = 1'b1;
    if (x.slave_data_byte) m_st[ist_pkg::BIT_DNA] = 1'b1;
    if (x.addr_match) m_st[ist_pkg::BIT_DNA] = 1'b0;
    if (x.start_seen) m_st[ist_pkg::BIT_STOP] = 1'b0;
    if (x.stop_seen) m_st[ist_pkg::BIT_STOP] = 1'b1;
    if (x.rx_byte_done && m_full) m_st[ist_pkg::BIT_ROV] = 1'b1;
    else if (x.rx_byte_done) {m_full, m_rx} = {1'b1, x.rx_byte};
  endtask
  task st_chk;
    axi_read(ist_pkg::ADDR_BUS_STATUS, d, r);
    chk(d & 32'hfffffff0, {16'h0, m_st & 16'hfff0});
  endtask
  task irq_chk(input logic v);
    repeat (3) @(posedge clk_sys);
    chk({31'h0, irq}, {31'h0, v});
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    #200000;
    errors++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(32'hedf9e382));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    st_chk();
    irq_chk(1'b0);
    // random event mix with software clears and receive reads
    for (int i = 0; i < 80; i++) begin
      d = $urandom & $urandom & $urandom;
      e = d[$bits(e)-1:0];
      e.busy = 1'b0;
      if (e.master_tx_start) e.ack_slot_end = 1'b0;
      e.ack_is_nack = 1'($urandom);
      e.master_op = 1'($urandom);
      i_ist_bus_peer.send(e);
      m_apply(e);
      st_chk();
      if ($urandom % 4 == 0) begin
        d = $urandom;
        axi_write(ist_pkg::ADDR_BUS_STATUS, d, r);
        m_st = m_st & ~(d[15:0] & ist_pkg::STATUS_W1C_MASK);
      end
      if (m_full && $urandom % 2) begin
        axi_read(ist_pkg::ADDR_RX_HOLDING, d, r);
        chk(d, {24'h0, m_rx});
        m_full = 1'b0;
      end
    end
    // transmit write while busy is discarded
    i_ist_bus_peer.set_busy(1'b1);
    axi_write(ist_pkg::ADDR_TX_HOLDING, 32'h5a, r);
    m_st[ist_pkg::BIT_WCOL] = 1'b1;
    chk({24'h0, tx_data}, 32'h0);
    i_ist_bus_peer.set_busy(1'b0);
    axi_write(ist_pkg::ADDR_TX_HOLDING, 32'ha5, r);
    chk({24'h0, tx_data}, 32'ha5);
    st_chk();
    // unmapped places are refused
    axi_write(8'h40, 32'h1, r);
    chk({30'h0, r}, {30'h0, ist_pkg::RESP_SLVERR});
    axi_read(8'h40, d, r);
    chk({d[29:0], r}, {30'h0, ist_pkg::RESP_SLVERR});
    // interrupt on stop: raise, mask, unmask, clear
    axi_write(ist_pkg::ADDR_IRQ_STATUS, 32'h3f, r);
    axi_write(ist_pkg::ADDR_IRQ_MASK, 32'h10, r);
    irq_chk(1'b0);
    e = '0;
    e.stop_seen = 1'b1;
    i_ist_bus_peer.send(e);
    m_apply(e);
    irq_chk(1'b1);
    axi_read(ist_pkg::ADDR_IRQ_STATUS, d, r);
    chk(d & 32'h10, 32'h10);
    axi_write(ist_pkg::ADDR_IRQ_MASK, 32'h0, r);
    irq_chk(1'b0);
    axi_write(ist_pkg::ADDR_IRQ_MASK, 32'h10, r);
    irq_chk(1'b1);
    axi_write(ist_pkg::ADDR_IRQ_STATUS, 32'h10, r);
    irq_chk(1'b0);
    st_chk();
    tally_and_finish();
  end
endmodule
bind ist_status_top ist_status_chk i_ist_status_chk (.*);
